// ---- hdl/sar_adc_pkg.sv ----
package sar_adc_pkg;
	// Converter geometry
	localparam int DATA_W = 12;
	localparam int CH_N = 8;
	localparam int CH_W = 3;
	localparam int ADDR_W = 8;

	// Register byte offsets
	localparam logic [7:0] OFS_RESULT0 = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h20;
	localparam logic [7:0] OFS_CHEN = 8'h24;
	localparam logic [7:0] OFS_CMP = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h2C;
	localparam logic [7:0] OFS_MASK = 8'h30;

	// Control register fields
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_MODE_LO = 2;
	localparam int CTRL_DIFF = 4;
	localparam int CTRL_TRIG_EN = 5;
	localparam int CTRL_CMP_INT = 6;
	localparam int CTRL_START = 8;
	localparam int CTRL_CAL = 9;

	// Channel enable register fields
	localparam int CHEN_MASK_LO = 0;
	localparam int CHEN_SRC_LO = 8;

	// Result word fields
	localparam int RES_DATA_LO = 0;
	localparam int RES_OVR_BIT = 16;
	localparam int RES_VALID_BIT = 17;

	// Status and mask fields
	localparam int ST_DONE = 0;
	localparam int ST_MATCH = 1;
	localparam int ST_CAL = 2;
	localparam int ST_W = 3;
	localparam int ST_BUSY_BIT = 8;
	localparam int ST_CH_LO = 9;

	// Only channels 0..3 exist as differential pairs
	localparam logic [7:0] DIFF_CH_MASK = 8'h0F;

	// Reset values
	localparam logic [7:0] CHEN_RESET = 8'h00;
	localparam logic [11:0] CMP_RESET = 12'h000;
	localparam logic [2:0] MASK_RESET = 3'h0;

	// Operating modes; code 01 behaves as single
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'b00,
		MODE_SCAN = 2'b10,
		MODE_CONT = 2'b11
	} adc_mode_e;

	// Channel 7 source selection
	typedef enum logic [1:0] {
		SRC_PIN = 2'b00,
		SRC_BANDGAP = 2'b01,
		SRC_TEMP = 2'b10,
		SRC_GND = 2'b11
	} ch7_src_e;

	// Sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_CONV = 2'b01,
		SEQ_CAL = 2'b10
	} seq_state_e;
endpackage

// ---- hdl/result_store.sv ----
`timescale 1ns/10ps
// Per-channel result memory, registered read port
module result_store (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	input wire logic wr_en,
	input wire logic [sar_adc_pkg::CH_W-1:0] wr_addr,
	input wire logic [sar_adc_pkg::DATA_W-1:0] wr_data,
	input wire logic [sar_adc_pkg::CH_W-1:0] rd_addr,
	output logic [sar_adc_pkg::DATA_W-1:0] rd_data
);
	// Whole memory plus read register
	typedef struct packed {
		logic [sar_adc_pkg::CH_N-1:0][sar_adc_pkg::DATA_W-1:0] mem;
		logic [sar_adc_pkg::DATA_W-1:0] rd;
	} store_s;

	store_s s;
	store_s next_s;

	// Read sees the old word when it hits a write; fine for polling
	always_comb begin
		next_s = s;
		next_s.rd = s.mem[rd_addr];
		if (wr_en) begin
			next_s.mem[wr_addr] = wr_data;
		end
	end

	// Frozen while the clock enable is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else if (pclk_en) begin
			s <= next_s;
		end
	end

	assign rd_data = s.rd;
endmodule

// ---- hdl/channel_pick.sv ----
`timescale 1ns/10ps
// Finds lowest enabled channel at or above a start index
module channel_pick (
	input wire logic [sar_adc_pkg::CH_N-1:0] en,
	input wire logic [sar_adc_pkg::CH_W:0] from,
	output logic found,
	output logic [sar_adc_pkg::CH_W-1:0] ch
);
	logic [sar_adc_pkg::CH_N-1:0] elig; // Enabled and not below start

	genvar i;
	generate
		for (i = 0; i < sar_adc_pkg::CH_N; i++) begin : g_elig
			assign elig[i] = en[i] && (4'(i) >= from);
		end
	endgenerate

	// Scan downward so the lowest eligible index wins
	always_comb begin
		found = 1'b0;
		ch = '0;
		for (int k = sar_adc_pkg::CH_N - 1; k >= 0; k--) begin
			if (elig[k]) begin
				found = 1'b1;
				ch = 3'(k);
			end
		end
	end
endmodule

// ---- hdl/sar_adc_sequencer.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Twelve-bit results, eight channels, one converter
// - Software picks single, scan or continuous mode
// - Single mode: one conversion, then stop
// - Scan: each enabled channel once, ascending
// - Continuous: repeat scans until software stops
// - Writing one to start bit begins sequence
// - External trigger pin edge also starts
// - Per-channel result with valid and overrun
// - Compare match raises interrupt when enabled
// - Channel 7 selects one of four sources
// - Eight single-ended or four differential channels
// - Software-invoked self-calibration
module sar_adc_sequencer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sar_adc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic external_trigger_pin,
	output logic core_power,
	output logic core_start,
	output logic core_cal_start,
	output logic [sar_adc_pkg::CH_W-1:0] core_channel,
	output logic core_diff,
	output logic [1:0] core_ch7_src,
	input wire logic core_done,
	input wire logic core_cal_done,
	input wire logic [sar_adc_pkg::DATA_W-1:0] core_result
);
	// One packed record holds every flop of the block except the result memory in u_store, so the
	// whole state moves or freezes together with the clock enable
	// All block state
	typedef struct packed {
		logic enable; // Converter powered
		logic [1:0] mode; // Operating mode code
		logic diff; // Differential pairs
		logic trig_en; // Pin trigger allowed
		logic cmp_int; // Compare match reporting
		logic start; // Conversion start bit
		logic cal; // Calibration request
		logic [7:0] chen; // Channel enables
		logic [1:0] ch7_src; // Channel 7 source
		logic [11:0] cmp_val; // Compare value
		logic [2:0] status; // Sticky events
		logic [2:0] mask; // Interrupt mask
		logic [7:0] valid; // Per-channel valid
		logic [7:0] overrun; // Per-channel overrun
		sar_adc_pkg::seq_state_e state; // Sequencer state
		logic [2:0] ch; // Channel in conversion
		logic core_start; // Start pulse to core
		logic cal_start; // Calibration pulse
		logic trig_prev; // Pin level last cycle
		logic acc_wait; // Access phase seen once
		logic [31:0] prdata; // Read data register
	} state_s;

	state_s s;
	state_s next_s;

	// Combinational helpers
	logic [7:0] eff_en; // Channels usable in this mode
	logic [3:0] next_from; // Search start after current
	logic first_found; // Some channel enabled
	logic [2:0] first_ch; // Lowest enabled channel
	logic next_found; // Higher channel remains
	logic [2:0] next_ch; // Next channel upward
	logic [11:0] mem_rd; // Stored result for read
	logic mem_wr; // Result write strobe
	logic acc_first; // First access cycle
	logic acc_done; // Transfer completes this edge
	logic wr; // Register write taken
	logic rd; // Register read taken
	logic [7:0] val_set; // Valid flags to set
	logic [7:0] val_clr; // Valid flags read off
	logic [7:0] ovr_set; // Overrun flags to set
	logic [2:0] st_set; // Status events this cycle
	logic is_scan; // Scan or continuous mode

	// Address decoding, shared by read mux, writes and refusal
	// Exact word match
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// Result words sit below the control register
	function automatic logic is_result(input logic [7:0] a);
		return (a < sar_adc_pkg::OFS_CTRL) && (a[1:0] == 2'h0);
	endfunction

	// Any decoded register
	function automatic logic mapped(input logic [7:0] a);
		return is_result(a) || hit(a, sar_adc_pkg::OFS_CTRL) ||
			hit(a, sar_adc_pkg::OFS_CHEN) || hit(a, sar_adc_pkg::OFS_CMP) ||
			hit(a, sar_adc_pkg::OFS_STATUS) || hit(a, sar_adc_pkg::OFS_MASK);
	endfunction

	// Differential mode hides the upper four channels
	// Upper enables are kept, so leaving the mode restores them
	assign eff_en = s.diff ? (s.chen & sar_adc_pkg::DIFF_CH_MASK) :
		s.chen;
	// Four bits so channel seven plus one does not wrap to zero
	assign next_from = {1'b0, s.ch} + 4'h1;
	assign is_scan = (s.mode == sar_adc_pkg::MODE_SCAN) ||
		(s.mode == sar_adc_pkg::MODE_CONT);

	// Lowest enabled channel, where every sequence begins
	// Searching from zero serves both a fresh start and a wrap
	channel_pick u_first (
		.en(eff_en),
		.from(4'h0),
		.found(first_found),
		.ch(first_ch)
	);

	// Next higher enabled channel during a scan
	// A start index of eight finds nothing, which ends the scan
	channel_pick u_next (
		.en(eff_en),
		.from(next_from),
		.found(next_found),
		.ch(next_ch)
	);

	// Results stored per channel
	// Only accepted while a conversion is owed; strays are ignored
	assign mem_wr = (s.state == sar_adc_pkg::SEQ_CONV) && core_done;
	result_store u_store (
		.pclk(pclk),
		.presetn(presetn),
		.pclk_en(pclk_en),
		.wr_en(mem_wr),
		.wr_addr(s.ch),
		.wr_data(core_result),
		.rd_addr(paddr[4:2]),
		.rd_data(mem_rd)
	);

	// One wait state: data registered in the first access cycle
	// The extra cycle lets the result memory register its word
	// A low clock enable also holds pready low, stretching access
	assign acc_first = psel && penable && !s.acc_wait;
	assign acc_done = psel && penable && s.acc_wait && pclk_en;
	assign wr = acc_done && pwrite;
	assign rd = acc_done && !pwrite;

	// Next state of everything
	// Pulses default low; other fields hold unless changed below
	always_comb begin
		next_s = s;
		next_s.core_start = 1'b0;
		next_s.cal_start = 1'b0;
		next_s.trig_prev = external_trigger_pin;
		val_set = '0;
		val_clr = '0;
		ovr_set = '0;
		st_set = '0;

		// Read data captured one cycle before pready
		if (acc_first) begin
			next_s.acc_wait = 1'b1;
			next_s.prdata = '0;
			// Unmapped reads fall through and return zero
			if (is_result(paddr)) begin
				next_s.prdata[sar_adc_pkg::RES_DATA_LO +: 12] = mem_rd;
				next_s.prdata[sar_adc_pkg::RES_OVR_BIT] = s.overrun[paddr[4:2]];
				next_s.prdata[sar_adc_pkg::RES_VALID_BIT] = s.valid[paddr[4:2]];
			end else if (hit(paddr, sar_adc_pkg::OFS_CTRL)) begin
				next_s.prdata[sar_adc_pkg::CTRL_ENABLE] = s.enable;
				next_s.prdata[sar_adc_pkg::CTRL_MODE_LO +: 2] = s.mode;
				next_s.prdata[sar_adc_pkg::CTRL_DIFF] = s.diff;
				next_s.prdata[sar_adc_pkg::CTRL_TRIG_EN] = s.trig_en;
				next_s.prdata[sar_adc_pkg::CTRL_CMP_INT] = s.cmp_int;
				next_s.prdata[sar_adc_pkg::CTRL_START] = s.start;
				next_s.prdata[sar_adc_pkg::CTRL_CAL] = s.cal;
			end else if (hit(paddr, sar_adc_pkg::OFS_CHEN)) begin
				next_s.prdata[sar_adc_pkg::CHEN_MASK_LO +: 8] = s.chen;
				next_s.prdata[sar_adc_pkg::CHEN_SRC_LO +: 2] = s.ch7_src;
			end else if (hit(paddr, sar_adc_pkg::OFS_CMP)) begin
				next_s.prdata[11:0] = s.cmp_val;
			end else if (hit(paddr, sar_adc_pkg::OFS_STATUS)) begin
				next_s.prdata[sar_adc_pkg::ST_W-1:0] = s.status;
				next_s.prdata[sar_adc_pkg::ST_BUSY_BIT] =
					(s.state != sar_adc_pkg::SEQ_IDLE);
				next_s.prdata[sar_adc_pkg::ST_CH_LO +: 3] = s.ch;
			end else if (hit(paddr, sar_adc_pkg::OFS_MASK)) begin
				next_s.prdata[sar_adc_pkg::ST_W-1:0] = s.mask;
			end
		end
		if (acc_done) begin
			next_s.acc_wait = 1'b0;
		end

		// Reading a result retires its flags
		// Overrun goes with valid, so one read leaves the channel clean
		if (rd && is_result(paddr)) begin
			val_clr[paddr[4:2]] = 1'b1;
		end

		// Sequencer
		// Idle waits for a request; conversion and calibration
		// own the core until it reports back
		case (s.state)
			sar_adc_pkg::SEQ_IDLE: begin
				// Calibration takes precedence over a pending start
				if (s.cal && s.enable) begin
					next_s.cal_start = 1'b1;
					next_s.state = sar_adc_pkg::SEQ_CAL;
				end else if (s.start && s.enable) begin
					if (first_found) begin
						next_s.ch = first_ch;
						next_s.core_start = 1'b1;
						next_s.state = sar_adc_pkg::SEQ_CONV;
					end else begin
						// Nothing enabled: end at once
						next_s.start = 1'b0;
					end
				end
			end
			sar_adc_pkg::SEQ_CONV: begin
				if (core_done) begin
					val_set[s.ch] = 1'b1;
					// Unread result overwritten
					ovr_set[s.ch] = s.valid[s.ch] && !val_clr[s.ch];
					if (s.cmp_int && (core_result == s.cmp_val)) begin
						st_set[sar_adc_pkg::ST_MATCH] = 1'b1;
					end
					// Scan step first, then wrap, otherwise finish
					if (is_scan && s.start && next_found) begin
						next_s.ch = next_ch;
						next_s.core_start = 1'b1;
					end else if ((s.mode == sar_adc_pkg::MODE_CONT) &&
						s.start && s.enable && first_found) begin
						// Wrap to lowest channel with no idle gap
						next_s.ch = first_ch;
						next_s.core_start = 1'b1;
					end else begin
						// Single, end of scan, or software halt
						next_s.start = 1'b0;
						st_set[sar_adc_pkg::ST_DONE] = 1'b1;
						next_s.state = sar_adc_pkg::SEQ_IDLE;
					end
				end
			end
			sar_adc_pkg::SEQ_CAL: begin
				if (core_cal_done) begin
					// Trim stays inside the core; only the event is kept
					next_s.cal = 1'b0;
					st_set[sar_adc_pkg::ST_CAL] = 1'b1;
					next_s.state = sar_adc_pkg::SEQ_IDLE;
				end
			end
			default: begin
				// Unused code: recover to idle
				next_s.state = sar_adc_pkg::SEQ_IDLE;
			end
		endcase

		// Software writes come after the sequencer so a fresh start wins
		// A mode change mid-sequence takes effect at the next done
		if (wr && hit(paddr, sar_adc_pkg::OFS_CTRL)) begin
			next_s.enable = pwdata[sar_adc_pkg::CTRL_ENABLE];
			next_s.mode = pwdata[sar_adc_pkg::CTRL_MODE_LO +: 2];
			next_s.diff = pwdata[sar_adc_pkg::CTRL_DIFF];
			next_s.trig_en = pwdata[sar_adc_pkg::CTRL_TRIG_EN];
			next_s.cmp_int = pwdata[sar_adc_pkg::CTRL_CMP_INT];
			next_s.start = pwdata[sar_adc_pkg::CTRL_START];
			// Calibration cannot be cancelled once asked for
			next_s.cal = s.cal | pwdata[sar_adc_pkg::CTRL_CAL];
		end
		// New enables apply from the next channel search onward
		if (wr && hit(paddr, sar_adc_pkg::OFS_CHEN)) begin
			next_s.chen = pwdata[sar_adc_pkg::CHEN_MASK_LO +: 8];
			next_s.ch7_src = pwdata[sar_adc_pkg::CHEN_SRC_LO +: 2];
		end
		// Compare value is used from the next result on
		if (wr && hit(paddr, sar_adc_pkg::OFS_CMP)) begin
			next_s.cmp_val = pwdata[11:0];
		end
		// Mask gates only the interrupt, never the status bits
		if (wr && hit(paddr, sar_adc_pkg::OFS_MASK)) begin
			next_s.mask = pwdata[sar_adc_pkg::ST_W-1:0];
		end

		// Rising edge on the trigger pin acts as a start write
		// Pin taken as synchronous; a level held high starts once
		if (s.enable && s.trig_en && external_trigger_pin && !s.trig_prev) begin
			next_s.start = 1'b1;
		end

		// Write-one-to-clear; a new event in the same cycle survives
		next_s.status = s.status;
		if (wr && hit(paddr, sar_adc_pkg::OFS_STATUS)) begin
			next_s.status = s.status & ~pwdata[sar_adc_pkg::ST_W-1:0];
		end
		next_s.status = next_s.status | st_set;

		// Set wins over a read in the same cycle
		next_s.valid = (s.valid & ~val_clr) | val_set;
		next_s.overrun = (s.overrun & ~val_clr) | ovr_set;
	end

	// State register; nothing moves while the clock enable is low
	// Reset gives idle, flags clear and the core powered down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.chen <= sar_adc_pkg::CHEN_RESET;
			s.cmp_val <= sar_adc_pkg::CMP_RESET;
			s.mask <= sar_adc_pkg::MASK_RESET;
			s.state <= sar_adc_pkg::SEQ_IDLE;
		end else if (pclk_en) begin
			s <= next_s;
		end
	end

	// Bus answer; pready held off while frozen so no write is lost
	// Refusal rides on the same cycle as the answer
	assign prdata = s.prdata;
	assign pready = s.acc_wait && pclk_en;
	assign pslverr = s.acc_wait && pclk_en && !mapped(paddr);

	// Level interrupt from unmasked sticky events
	// Stays high until software clears the status bit or masks it
	assign irq = |(s.status & s.mask);

	// Converter core controls, all registered
	// Registered so the core never sees a decode glitch
	assign core_power = s.enable;
	assign core_start = s.core_start;
	assign core_cal_start = s.cal_start;
	assign core_channel = s.ch;
	assign core_diff = s.diff;
	assign core_ch7_src = s.ch7_src;
endmodule

// ---- verification/sar_adc_sequencer_chk.sv ----
`timescale 1ns/10ps
// Port checks on the APB slave and the core side
module sar_adc_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sar_adc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic core_power,
	input wire logic core_start,
	input wire logic core_cal_start,
	input wire logic [sar_adc_pkg::CH_W-1:0] core_channel,
	input wire logic core_diff
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Answer only after one full wait state
	AST_PREADY_WAIT: assert property (pready |-> psel && penable
		&& $past(psel && penable)) else $error("pready too early");
	AST_PREADY_ONE: assert property (pready |=> !pready)
		else $error("pready held");
	AST_SLVERR: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	// Refusal follows the map: aligned words up to the mask
	AST_REFUSE_MAP: assert property (pready |-> pslverr ==
		((paddr[1:0] != 2'h0) || (paddr > sar_adc_pkg::OFS_MASK)))
		else $error("refusal does not match map");
	// Refused reads return zero
	AST_UNMAPPED_ZERO: assert property (pslverr && !pwrite |->
		prdata == 32'h0) else $error("unmapped read not zero");
	AST_START_PULSE: assert property (core_start |=> !core_start)
		else $error("start pulse too long");
	AST_CAL_PULSE: assert property (
		core_cal_start |=> !core_cal_start)
		else $error("cal pulse too long");
	// No conversion while the converter is off
	AST_START_POWER: assert property (core_start |-> core_power)
		else $error("start while off");
	// Channel only moves with a new start
	AST_CH_STABLE: assert property ($changed(core_channel) |->
		core_start) else $error("channel moved mid conversion");
	AST_DIFF_CH: assert property (core_start && core_diff |->
		core_channel <= 3'h3) else $error("bad differential channel");
	COV_DIFF: cover property (core_start && core_diff);
	COV_CAL: cover property (core_cal_start);
	COV_REFUSE: cover property (pslverr);
endmodule

bind sar_adc_sequencer sar_adc_chk i_sar_adc_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .core_power,
	.core_start, .core_cal_start, .core_channel, .core_diff);

// ---- verification/core_model.sv ----
`timescale 1ns/10ps
// Behavioural converter core, fixed result per channel
module core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic core_start,
	input wire logic core_cal_start,
	input wire logic [2:0] core_channel,
	output logic core_done,
	output logic core_cal_done,
	output logic [11:0] core_result
);
	logic [2:0] log[$]; // Channels in conversion order
	logic [2:0] ch; // Channel in conversion
	int cnt; // Conversion cycles left
	int ccnt; // Calibration cycles left
	// Slow mode stretches conversions to test waiting
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			ccnt <= 0;
			core_done <= 1'h0;
			core_cal_done <= 1'h0;
			core_result <= 12'h0;
		end else begin
			if (core_start) begin
				ch <= core_channel;
				cnt <= slow ? 8 : 2;
				log.push_back(core_channel);
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
			ccnt <= core_cal_start ? 3 : (ccnt != 0 ? ccnt - 1 : 0);
			core_done <= cnt == 1;
			core_cal_done <= ccnt == 1;
			// Bus toggles outside the done cycle, never holds
			core_result <= (cnt == 1) ? (12'hFF0 | 12'(ch)) : ~core_result;
		end
	end
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/10ps
// Self-checking bench for the sequencer
module tb;
	logic pclk, presetn, psel, penable, pwrite, trig_pin, slow, perr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, irq, core_power, core_start, core_cal_start;
	logic core_diff, core_done, core_cal_done;
	logic [2:0] core_channel;
	logic [1:0] core_ch7_src;
	logic [11:0] core_result;
	int err_total, tests_run;
	sar_adc_sequencer i_sar_adc_sequencer (.pclk, .presetn,
		.pclk_en(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .irq,
		.external_trigger_pin(trig_pin), .core_power, .core_start,
		.core_cal_start, .core_channel, .core_diff, .core_ch7_src,
		.core_done, .core_cal_done, .core_result);
	core_model i_core_model (.pclk, .presetn, .slow, .core_start,
		.core_cal_start, .core_channel, .core_done, .core_cal_done,
		.core_result);
	// Clock, 20 ns period
	initial begin
		pclk = 1'h0;
		forever #10 pclk = ~pclk;
	end
	// One APB transfer, request held until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// No cycle count assumed; only the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		q = prdata;
		perr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// Compare one word
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Expected result word
	function automatic logic [31:0] rw(input logic v, input logic o,
		input logic [2:0] c);
		return {14'h0, v, o, 4'h0, 12'hFF0 | 12'(c)};
	endfunction
	// Poll a status bit, bounded
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(0, 8'h2C, 0);
			n++;
		end while (q[b] !== v && n < 100);
		if (n >= 100) begin
			err_total++;
			$display("BAD %0t status poll timed out", $time);
		end
	endtask
	// Wait for idle; start bit must have cleared
	task automatic wait_idle();
		poll(8, 1'h0);
		apb(0, 8'h20, 0);
		chk(q & 32'h100, 0);
	endtask
	// Wait for conversions seen by the core, bounded
	task automatic wait_log(input int m);
		int n;
		n = 0;
		while (i_core_model.log.size() < m && n < 300) begin
			@(posedge pclk);
			n++;
		end
	endtask
	// Reset values, unmapped access refused
	task automatic t_regs();
		for (int a = 32; a <= 48; a += 4) begin
			apb(0, 8'(a), 0);
			chk(q, 0);
		end
		apb(1, 8'h40, 32'hFFFFFFFF);
		apb(0, 8'h40, 0);
		chk({q[30:0], perr}, 1);
		chk({31'h0, irq}, 0);
		$display("test regs done");
	endtask
	// Single mode on lowest enabled channel
	task automatic t_single();
		i_core_model.log.delete();
		apb(1, 8'h30, 1);
		// Analog inputs set up before the converter is powered
		apb(1, 8'h24, 32'h24);
		apb(1, 8'h20, 32'h101);
		wait_idle();
		chk({31'h0, core_power}, 1);
		chk(i_core_model.log.size(), 1);
		chk(i_core_model.log[0], 2);
		chk({31'h0, irq}, 1);
		apb(0, 8'h08, 0);
		chk(q, rw(1, 0, 2));
		apb(0, 8'h14, 0);
		chk(q, 0);
		apb(0, 8'h08, 0);
		chk(q, rw(0, 0, 2));
		apb(1, 8'h2C, 1);
		@(negedge pclk);
		chk({31'h0, irq}, 0);
		$display("test single done");
	endtask
	// Two scans, second slow, leaves overrun
	task automatic t_scan();
		logic [2:0] sc[3];
		sc = '{3'h1, 3'h3, 3'h7};
		i_core_model.log.delete();
		apb(1, 8'h24, 32'h8A);
		for (int k = 0; k < 2; k++) begin
			slow <= k[0];
			apb(1, 8'h20, 32'h109);
			wait_idle();
		end
		chk(i_core_model.log.size(), 6);
		for (int k = 0; k < 6; k++) chk(i_core_model.log[k], sc[k % 3]);
		for (int k = 0; k < 3; k++) begin
			apb(0, 8'(sc[k] * 4), 0);
			chk(q, rw(1, 1, sc[k]));
		end
		$display("test scan done");
	endtask
	// Continuous scan wraps until halted
	task automatic t_cont();
		i_core_model.log.delete();
		apb(1, 8'h24, 32'h03);
		apb(1, 8'h20, 32'h10D);
		wait_log(5);
		apb(1, 8'h20, 32'h00D);
		wait_idle();
		chk(i_core_model.log.size() >= 5, 1);
		for (int k = 0; k < i_core_model.log.size(); k++) begin
			chk(i_core_model.log[k], k & 1);
		end
		$display("test cont done");
	endtask
	// Trigger pin edge starts single mode
	task automatic t_trig();
		i_core_model.log.delete();
		apb(1, 8'h24, 32'h10);
		apb(1, 8'h20, 32'h21);
		trig_pin <= 1'h1;
		repeat (3) @(posedge pclk);
		trig_pin <= 1'h0;
		wait_log(1);
		wait_idle();
		chk(i_core_model.log.size(), 1);
		chk(i_core_model.log[0], 4);
		$display("test trig done");
	endtask
	// Compare match sets status and interrupt
	task automatic t_cmp();
		apb(1, 8'h28, 32'hFF6);
		apb(1, 8'h30, 2);
		apb(1, 8'h24, 32'h40);
		apb(1, 8'h20, 32'h141);
		wait_idle();
		apb(0, 8'h2C, 0);
		chk(q & 2, 2);
		chk({31'h0, irq}, 1);
		apb(1, 8'h30, 0);
		@(negedge pclk);
		chk({31'h0, irq}, 0);
		apb(1, 8'h2C, 7);
		$display("test cmp done");
	endtask
	// Differential scan uses channels 0..3
	task automatic t_diff();
		i_core_model.log.delete();
		apb(1, 8'h24, 32'hFF);
		apb(1, 8'h20, 32'h119);
		wait_idle();
		chk(i_core_model.log.size(), 4);
		for (int k = 0; k < 4; k++) chk(i_core_model.log[k], k);
		chk({31'h0, core_diff}, 1);
		$display("test diff done");
	endtask
	// All four channel 7 sources, then calibration
	task automatic t_src_cal();
		for (int s = 0; s < 4; s++) begin
			apb(1, 8'h24, {22'h0, 2'(s), 8'h01});
			@(negedge pclk);
			chk(core_ch7_src, s);
		end
		apb(1, 8'h30, 4);
		apb(1, 8'h20, 32'h201);
		poll(2, 1'h1);
		chk({31'h0, irq}, 1);
		$display("test src cal done");
	endtask
	// Verdict and end of run
	task automatic finish_test();
		$display("Counts: %0d checks, %0d mismatches", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		$display("BAD %0t watchdog expired", $time);
		finish_test();
	end
	// Main sequence
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		trig_pin = 1'h0;
		slow = 1'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_single();
		t_scan();
		t_cont();
		t_trig();
		t_cmp();
		t_diff();
		t_src_cal();
		finish_test();
	end
endmodule
